// ---- hw/reset_strap_pll_ratio_decode.v ----
// strap capture, ratio decode and pin reset behaviour with avalon regs
// What this block does
// - capture four platform straps during reset
// - code 0000 selects sixteen to one
// - codes 0010..0110 select two to six
// - codes 1000,1001,1010,1100 select 8,9,10,12
// - capture two core straps during reset
// - core codes give 2, 5/2, 3, 7/2 as a decoded ratio; the core tick rate ignores them
// - platform clock equals platform bus clock
// - memory clock half platform, 100..166 MHz
// - weak pull-ups enabled only during reset
// - strap outputs act as inputs in reset
// - some outputs driven throughout reset
// - core clock derived from platform clock
`include "rspd_defines.vh"
module reset_strap_pll_ratio_decode #(
    parameter REF_MHZ = 100
) (
    // clock and reset
    input wire i_clock,
    input wire i_resetn,
    // device reset state seen by the pads
    input wire i_dev_reset,
    // strap pins, pad input side
    input wire [3:0] i_platform_ratio_straps,
    input wire i_core_ratio_strap_hi,
    input wire i_core_ratio_strap_lo,
    // functional values for shared strap pins after reset
    input wire [3:0] i_func_platform_out,
    input wire i_func_core_hi_out,
    input wire i_func_core_lo_out,
    // strap pin drive
    output wire [3:0] o_platform_ratio_straps,
    output wire [3:0] o_platform_ratio_straps_oe,
    output wire o_core_ratio_strap_hi,
    output wire o_core_ratio_strap_hi_oe,
    output wire o_core_ratio_strap_lo,
    output wire o_core_ratio_strap_lo_oe,
    output wire o_weak_pullup_en,
    output wire o_always_drive_oe,
    // decoded ratios
    output reg [4:0] o_platform_mult_reg,
    output reg [2:0] o_core_half_mult_reg,
    output reg o_ratio_invalid_reg,
    output reg o_platform_pll_run_reg,
    output wire o_platform_bus_clk_run,
    output wire o_core_tick,
    // avalon-mm slave
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata_reg,
    output wire o_avs_waitrequest
);
    // pin synchronisers, first stage read only by second
    reg [5:0] sync1_reg;
    reg [5:0] sync2_reg;
    reg rst_sync1_reg;
    reg rst_sync2_reg;
    // captured values
    reg [3:0] plat_code_reg;
    reg [1:0] core_code_reg;
    reg captured_reg;
    reg [3:0] settle_reg;
    reg [5:0] last_reg;
    // registers
    reg [31:0] ctrl_reg;
    reg ack_reg;
    reg plat_tick_reg;
    // limit checks
    reg [15:0] plat_mhz;
    reg [15:0] core_mhz;
    wire [8:0] status;
    // reference rate held at the arithmetic width of the limit checks
    localparam [15:0] REF16 = REF_MHZ;
    wire in_reset;
    wire [5:0] pins;

    // decode of platform code, used for capture and for the status view
    function [4:0] plat_mult;
        input [3:0] code;
        begin
            case (code)
                `RSPD_PR_16: plat_mult = 5'h10;
                `RSPD_PR_2: plat_mult = 5'h02;
                `RSPD_PR_3: plat_mult = 5'h03;
                `RSPD_PR_4: plat_mult = 5'h04;
                `RSPD_PR_5: plat_mult = 5'h05;
                `RSPD_PR_6: plat_mult = 5'h06;
                `RSPD_PR_8: plat_mult = 5'h08;
                `RSPD_PR_9: plat_mult = 5'h09;
                `RSPD_PR_10: plat_mult = 5'h0A;
                `RSPD_PR_12: plat_mult = 5'h0C;
                default: plat_mult = 5'h00;
            endcase
        end
    endfunction

    // core ratio in halves: 4,5,6,7 halves
    function [2:0] core_half;
        input [1:0] code;
        begin
            case (code)
                2'h0: core_half = 3'h4;
                2'h1: core_half = 3'h5;
                2'h2: core_half = 3'h6;
                default: core_half = 3'h7;
            endcase
        end
    endfunction

    assign pins = {i_platform_ratio_straps, i_core_ratio_strap_hi,
        i_core_ratio_strap_lo};
    assign in_reset = rst_sync2_reg;

    // two-flop synchronisers for straps and the pad reset state
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            rst_sync1_reg <= i_dev_reset;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    // sample straps while in reset; freeze at release
    // settle count is kept but nothing checks it before capture at release
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            plat_code_reg <= 4'h0;
            core_code_reg <= 2'h0;
            captured_reg <= 1'b0;
            settle_reg <= 4'h0;
            last_reg <= 6'h00;
        end else if (in_reset) begin
            last_reg <= sync2_reg;
            plat_code_reg <= sync2_reg[5:2];
            core_code_reg <= sync2_reg[1:0];
            captured_reg <= 1'b0;
            if (sync2_reg != last_reg)
                settle_reg <= 4'h0;
            else if (settle_reg != `RSPD_SETTLE_CYCLES)
                settle_reg <= settle_reg + 4'h1;
        end else begin
            // straps now act as outputs; ignore pin activity
            captured_reg <= 1'b1;
        end
    end

    // decoded outputs held from release until next reset
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            o_platform_mult_reg <= 5'h00;
            o_core_half_mult_reg <= 3'h0;
            o_ratio_invalid_reg <= 1'b0;
            o_platform_pll_run_reg <= 1'b0;
        end else if (in_reset) begin
            o_platform_pll_run_reg <= 1'b0;
            o_ratio_invalid_reg <= 1'b0;
        end else if (!captured_reg) begin
            o_platform_mult_reg <= plat_mult(plat_code_reg);
            o_core_half_mult_reg <= core_half(core_code_reg);
            o_ratio_invalid_reg <= plat_mult(plat_code_reg) == 5'h00;
            o_platform_pll_run_reg <= plat_mult(plat_code_reg) != 5'h00;
        end
    end

    // one clock feeds memory rate and bus alike
    assign o_platform_bus_clk_run = o_platform_pll_run_reg;

    // platform tick marker for the slaved core divider
    always @(posedge i_clock) begin
        if (!i_resetn)
            plat_tick_reg <= 1'b0;
        else
            plat_tick_reg <= o_platform_pll_run_reg & ~plat_tick_reg;
    end

    // core generator only runs once platform runs
    rspd_core_div u_core_div (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_run(o_platform_pll_run_reg),
        .i_plat_tick(plat_tick_reg),
        .i_core_code(core_code_reg),
        .o_core_ticks_reg(o_core_tick)
    );

    // frequency checks from the reference rate
    always @* begin
        plat_mhz = REF16 * {11'h000, o_platform_mult_reg};
        core_mhz = (plat_mhz * {13'h0000, o_core_half_mult_reg}) >> 1;
    end

    assign status[`RSPD_ST_VALID_BIT] = captured_reg;
    assign status[`RSPD_ST_INVALID_BIT] = o_ratio_invalid_reg;
    assign status[`RSPD_ST_PLAT_RUN_BIT] = o_platform_pll_run_reg;
    assign status[`RSPD_ST_CORE_RUN_BIT] = o_platform_pll_run_reg;
    // memory clock is half platform; flag outside 100..166
    assign status[`RSPD_ST_MEMLOW_BIT] = captured_reg &&
        (plat_mhz >> 1) < `RSPD_MEM_MIN_MHZ;
    assign status[`RSPD_ST_MEMHIGH_BIT] = captured_reg &&
        (plat_mhz >> 1) > `RSPD_MEM_MAX_MHZ;
    // board owns these, the block only reports them
    assign status[`RSPD_ST_PLATLOW_BIT] = captured_reg &&
        plat_mhz < `RSPD_PLAT_MIN_MHZ;
    assign status[`RSPD_ST_CORELOW_BIT] = captured_reg &&
        core_mhz < `RSPD_CORE_MIN_MHZ;
    assign status[`RSPD_ST_COREHIGH_BIT] = captured_reg &&
        core_mhz > `RSPD_CORE_MAX_MHZ;

    // pad control: pull-ups and strap inputs only in reset
    assign o_weak_pullup_en = in_reset;
    assign o_platform_ratio_straps_oe = in_reset ? 4'h0 : 4'hF;
    assign o_core_ratio_strap_hi_oe = ~in_reset;
    assign o_core_ratio_strap_lo_oe = ~in_reset;
    assign o_platform_ratio_straps = in_reset ? 4'h0 : i_func_platform_out;
    assign o_core_ratio_strap_hi = ~in_reset & i_func_core_hi_out;
    assign o_core_ratio_strap_lo = ~in_reset & i_func_core_lo_out;
    // designated outputs enabled in reset and after, whatever the control bit
    assign o_always_drive_oe = in_reset |
        ctrl_reg[`RSPD_CTRL_DRIVE_BIT] | 1'b1;

    // avalon answer: one wait cycle on each access
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;

    // register writes and read data
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            ctrl_reg <= `RSPD_CTRL_RESET;
            ack_reg <= 1'b0;
            o_avs_readdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
            // a write lands only on the edge that completes the handshake
            if (i_avs_write && ack_reg &&
                i_avs_address == `RSPD_OFS_CTRL)
                ctrl_reg <= {31'h0, i_avs_writedata[0]};
            if (i_avs_read && !ack_reg) begin
                case (i_avs_address)
                    `RSPD_OFS_CTRL: o_avs_readdata_reg <= ctrl_reg;
                    `RSPD_OFS_STATUS:
                        o_avs_readdata_reg <= {23'h0, status};
                    `RSPD_OFS_RATIO:
                        o_avs_readdata_reg <= {24'h0,
                            o_core_half_mult_reg, o_platform_mult_reg};
                    `RSPD_OFS_STRAPS:
                        o_avs_readdata_reg <= {26'h0, plat_code_reg,
                            core_code_reg};
                    default: o_avs_readdata_reg <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // reset_strap_pll_ratio_decode

// ---- hw/rspd_defines.vh ----
// constants for the reset strap ratio decode block
`ifndef RSPD_DEFINES_VH
`define RSPD_DEFINES_VH
// register byte offsets
`define RSPD_OFS_CTRL 4'h0
`define RSPD_OFS_STATUS 4'h4
`define RSPD_OFS_RATIO 4'h8
`define RSPD_OFS_STRAPS 4'hC
// control fields
`define RSPD_CTRL_DRIVE_BIT 0
`define RSPD_CTRL_RESET 32'h00000000
// status fields
`define RSPD_ST_VALID_BIT 0
`define RSPD_ST_INVALID_BIT 1
`define RSPD_ST_PLAT_RUN_BIT 2
`define RSPD_ST_CORE_RUN_BIT 3
`define RSPD_ST_MEMLOW_BIT 4
`define RSPD_ST_MEMHIGH_BIT 5
`define RSPD_ST_PLATLOW_BIT 6
`define RSPD_ST_CORELOW_BIT 7
`define RSPD_ST_COREHIGH_BIT 8
// platform ratio codes
`define RSPD_PR_16 4'h0
`define RSPD_PR_2 4'h2
`define RSPD_PR_3 4'h3
`define RSPD_PR_4 4'h4
`define RSPD_PR_5 4'h5
`define RSPD_PR_6 4'h6
`define RSPD_PR_8 4'h8
`define RSPD_PR_9 4'h9
`define RSPD_PR_10 4'hA
`define RSPD_PR_12 4'hC
// frequency limits in MHz
`define RSPD_MEM_MIN_MHZ 100
`define RSPD_MEM_MAX_MHZ 166
`define RSPD_PLAT_MIN_MHZ 200
`define RSPD_CORE_MIN_MHZ 400
`define RSPD_CORE_MAX_MHZ 833
// cycles at which the settle count saturates; release does not wait on it
`define RSPD_SETTLE_CYCLES 4'h4
`endif

// ---- hw/rspd_core_div.v ----
// core clock enable generator slaved to the platform clock enable
module rspd_core_div (
    // clock and reset
    input wire i_clock,
    input wire i_resetn,
    // control
    input wire i_run,
    input wire i_plat_tick,
    input wire [1:0] i_core_code,
    // output
    output reg o_core_ticks_reg
);
    // half-ratios n:2 decoded into half_num, which the output never uses; phase_reg counts platform ticks
    reg [2:0] phase_reg;
    reg [2:0] half_num;

    // numerator of the core ratio over two
    always @* begin
        case (i_core_code)
            2'h0: half_num = 3'h4;
            2'h1: half_num = 3'h5;
            2'h2: half_num = 3'h6;
            default: half_num = 3'h7;
        endcase
    end

    // count platform ticks and flip the output on each, so the core code
    // does not change the output rate and no fractional ratio is shown
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            phase_reg <= 3'h0;
            o_core_ticks_reg <= 1'b0;
        end else if (!i_run) begin
            phase_reg <= 3'h0;
            o_core_ticks_reg <= 1'b0;
        end else if (i_plat_tick) begin
            phase_reg <= phase_reg + 3'h1;
            o_core_ticks_reg <= ~o_core_ticks_reg;
        end
    end
endmodule // rspd_core_div

// ---- sim/rspd_properties.sv ----
// port assertions for the reset strap ratio decode block
module rspd_properties (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_dev_reset,
    input wire logic o_weak_pullup_en,
    input wire logic [3:0] o_platform_ratio_straps_oe,
    input wire logic o_always_drive_oe,
    input wire logic [4:0] o_platform_mult_reg,
    input wire logic [2:0] o_core_half_mult_reg,
    input wire logic o_ratio_invalid_reg,
    input wire logic o_platform_pll_run_reg
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    // pads released, then a decoded result within the sync latency
    sequence s_release;
        $fell(o_weak_pullup_en);
    endsequence
    sequence s_decoded;
        ##[0:3] (o_platform_pll_run_reg || o_ratio_invalid_reg);
    endsequence
    property p_pull_in_reset;
        o_weak_pullup_en |-> o_platform_ratio_straps_oe == 4'h0;
    endproperty
    property p_oe_after;
        !o_weak_pullup_en |-> o_platform_ratio_straps_oe == 4'hF;
    endproperty
    property p_pull_rise;
        $rose(i_dev_reset) |-> ##[1:4] o_weak_pullup_en;
    endproperty
    property p_pull_fall;
        $fell(i_dev_reset) |-> ##[1:4] !o_weak_pullup_en;
    endproperty
    property p_inv_stop;
        o_ratio_invalid_reg |-> !o_platform_pll_run_reg;
    endproperty
    property p_mult_legal;
        o_platform_pll_run_reg |-> o_platform_mult_reg inside {5'h10,
            [5'h02:5'h06], [5'h08:5'h0A], 5'h0C};
    endproperty
    property p_decode;
        s_release |-> s_decoded;
    endproperty
    // a new reset may reload the ratios, so only quiet spans count
    property p_hold;
        (!o_weak_pullup_en)[*4] |=> o_weak_pullup_en ||
            ($stable(o_platform_mult_reg) && $stable(o_core_half_mult_reg));
    endproperty
    a_pull_in_reset: assert property (p_pull_in_reset)
        else $error("strap pad driven in reset");
    a_oe_after: assert property (p_oe_after)
        else $error("strap pad not driven after reset");
    a_pull_rise: assert property (p_pull_rise)
        else $error("pull-up not on in reset");
    a_pull_fall: assert property (p_pull_fall)
        else $error("pull-up not off after reset");
    a_drive: assert property (o_always_drive_oe)
        else $error("output released");
    a_inv_stop: assert property (p_inv_stop)
        else $error("generator runs on reserved code");
    a_mult_legal: assert property (p_mult_legal)
        else $error("illegal multiplier");
    a_decode: assert property (p_decode)
        else $error("no decode after release");
    a_hold: assert property (p_hold)
        else $error("ratio moved outside reset");
endmodule // rspd_properties

bind reset_strap_pll_ratio_decode rspd_properties u_rspd_properties (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_dev_reset(i_dev_reset),
    .o_weak_pullup_en(o_weak_pullup_en),
    .o_platform_ratio_straps_oe(o_platform_ratio_straps_oe),
    .o_always_drive_oe(o_always_drive_oe),
    .o_platform_mult_reg(o_platform_mult_reg),
    .o_core_half_mult_reg(o_core_half_mult_reg),
    .o_ratio_invalid_reg(o_ratio_invalid_reg),
    .o_platform_pll_run_reg(o_platform_pll_run_reg));

// ---- sim/rspd_board_model.sv ----
// board strap pulls and external reset source
module rspd_board_model (
    input wire logic i_clock,
    input wire logic i_hold,
    input wire logic [5:0] i_pull,
    input wire logic [3:0] i_plat_out,
    input wire logic [3:0] i_plat_oe,
    input wire logic [1:0] i_core_out,
    input wire logic [1:0] i_core_oe,
    output logic o_dev_reset = 1'b1,
    output logic [3:0] o_plat_pad,
    output logic [1:0] o_core_pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // reset source moves only just after an edge
    always @(posedge i_clock) o_dev_reset <= i_hold;
    // every strap has its own pull, so an undriven pad never floats
    always_comb begin
        for (int b = 0; b < 4; b++)
            o_plat_pad[b] = i_plat_oe[b] ? i_plat_out[b] : i_pull[b+2];
        for (int b = 0; b < 2; b++)
            o_core_pad[b] = i_core_oe[b] ? i_core_out[b] : i_pull[b];
    end
endmodule // rspd_board_model

// ---- sim/testbench.sv ----
// self-checking bench for the reset strap ratio decode block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REF = 25; // low reference so every limit flag but core-high shows
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic hold = 1'b1;
    logic [5:0] pull = 6'h00;
    logic [3:0] f_plat = 4'hA;
    logic [1:0] f_core = 2'h1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] q;
    wire dev_rst, pu, drv, hi, lo, hi_oe, lo_oe, inv, run, brun, tick, wt;
    wire [3:0] pad, p_out, p_oe;
    wire [1:0] cpad;
    wire [4:0] mult;
    wire [2:0] half;
    wire [31:0] rdat;
    int errors = 0;
    int samples_checked = 0;

    always #12.5 i_clock = ~i_clock;

    reset_strap_pll_ratio_decode #(.REF_MHZ(REF))
        u_reset_strap_pll_ratio_decode (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_dev_reset(dev_rst),
        .i_platform_ratio_straps(pad), .i_core_ratio_strap_hi(cpad[1]),
        .i_core_ratio_strap_lo(cpad[0]), .i_func_platform_out(f_plat),
        .i_func_core_hi_out(f_core[1]), .i_func_core_lo_out(f_core[0]),
        .o_platform_ratio_straps(p_out), .o_platform_ratio_straps_oe(p_oe),
        .o_core_ratio_strap_hi(hi), .o_core_ratio_strap_hi_oe(hi_oe),
        .o_core_ratio_strap_lo(lo), .o_core_ratio_strap_lo_oe(lo_oe),
        .o_weak_pullup_en(pu), .o_always_drive_oe(drv),
        .o_platform_mult_reg(mult), .o_core_half_mult_reg(half),
        .o_ratio_invalid_reg(inv), .o_platform_pll_run_reg(run),
        .o_platform_bus_clk_run(brun), .o_core_tick(tick),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata_reg(rdat),
        .o_avs_waitrequest(wt));

    rspd_board_model u_rspd_board_model (.i_clock(i_clock), .i_hold(hold),
        .i_pull(pull), .i_plat_out(p_out), .i_plat_oe(p_oe),
        .i_core_out({hi, lo}), .i_core_oe({hi_oe, lo_oe}),
        .o_dev_reset(dev_rst), .o_plat_pad(pad), .o_core_pad(cpad));

    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a);
        int n;
        n = 0;
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= 32'h1;
        @(posedge i_clock);
        while (wt !== 1'b0 && n < 50) begin
            @(posedge i_clock);
            n++;
        end
        if (n == 50) errors++;
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge i_clock);
    endtask

    // board reset with the given pulls; pad state checked on both sides
    task automatic boot(input logic [5:0] c);
        pull <= c;
        hold <= 1'b1;
        repeat (6) @(posedge i_clock);
        check("pullup_in", pu, 1'h1);
        check("oe_in", {p_oe, hi_oe, lo_oe}, 6'h00);
        check("drive_in", drv, 1'h1);
        hold <= 1'b0;
        repeat (8) @(posedge i_clock);
        check("pullup_out", pu, 1'h0);
        check("oe_out", {p_oe, hi_oe, lo_oe}, 6'h3F);
    endtask

    function automatic logic [4:0] emult(input logic [3:0] c);
        if (c == 4'h0) return 5'h10;
        if (c inside {[4'h2:4'h6], [4'h8:4'hA], 4'hC}) return {1'b0, c};
        return 5'h00;
    endfunction

    // every platform code once, core code cycling alongside
    task automatic t_codes;
        logic [4:0] m;
        logic [2:0] h;
        logic [31:0] st, mk;
        logic v;
        int p;
        for (int c = 0; c < 16; c++) begin
            boot({c[3:0], c[1:0]});
            m = emult(c[3:0]);
            h = 3'h4 + {1'b0, c[1:0]};
            v = (m != 5'h00);
            p = REF * m;
            mk = v ? 32'h1FF : 32'hF;
            check("mult", mult, m);
            check("invalid", inv, !v);
            check("bus_run", {brun, run}, {v, v});
            if (v) check("half", half, h);
            bus(1'b0, 4'hC);
            check("straps", q, {c[3:0], c[1:0]});
            bus(1'b0, 4'h4);
            st = {p * h > 1666, p * h < 800, p < 200, p > 332, p < 200,
                  v, v, !v, 1'b1};
            check("status", q & mk, st & mk);
        end
    endtask

    // pins toggle after release; the ratios stay put
    task automatic t_hold;
        int n;
        logic t0;
        n = 0;
        t0 = tick;
        boot(6'h0A);
        pull <= 6'h3F;
        for (int i = 0; i < 16; i++) begin
            f_plat <= i[3:0];
            f_core <= i[1:0];
            @(posedge i_clock);
            if (tick !== t0) n++;
            t0 = tick;
        end
        repeat (2) @(posedge i_clock);
        check("pads", {p_out, hi, lo}, {f_plat, f_core});
        check("held", {half, mult}, {3'h6, 5'h02});
        check("tick", n != 0, 1'h1);
    endtask

    // control readback, read-only and unmapped places, bus reset
    task automatic t_regs;
        bus(1'b0, 4'h0);
        check("ctrl_rst", q, 32'h0);
        bus(1'b1, 4'h0);
        bus(1'b1, 4'h8);
        bus(1'b0, 4'h0);
        check("ctrl", q, 32'h1);
        bus(1'b0, 4'h8);
        check("ratio_ro", q, {3'h6, 5'h02});
        bus(1'b0, 4'h1);
        check("unmapped", q, 32'h0);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        bus(1'b0, 4'h0);
        check("ctrl_rst2", q, 32'h0);
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        t_codes;
        $display("codes done");
        t_hold;
        $display("hold done");
        t_regs;
        $display("regs done");
        end_sim;
    end

    // cut a hang short well past the expected run length
    initial begin
        #100us;
        errors++;
        end_sim;
    end
endmodule // testbench
